// >>> shared/cfg_loader_pkg.sv
// Constants, field layouts and types shared by the configuration loader.
// Assumes a single 50 MHz system clock and an APB master for software access.
package cfg_loader_pkg;

  // Image geometry
  localparam int ARRAY_CELLS = 5828;
  localparam int SIG_CELLS   = 64;
  localparam int FULL_CELLS  = 5892;
  localparam int IDX_W       = 13;
  localparam int OUT_NUM     = 10;
  localparam logic [IDX_W-1:0] STD_LAST  = 13'h16c3;  // 5827
  localparam logic [IDX_W-1:0] FULL_LAST = 13'h1703;  // 5891
  localparam logic [IDX_W-1:0] SIG_LAST  = 13'h003f;  // 63
  localparam logic [IDX_W-1:0] SIG_BASE  = 13'h16c4;  // 5828

  // Cells holding per-output polarity and enable
  localparam int POL_CELL0 = 5808;
  localparam int OE_CELL0  = 5818;

  // Serial command codes, shifted in LSB first
  localparam int CMD_W = 4;
  localparam logic [CMD_W-1:0] CMD_ERASE     = 4'h1;
  localparam logic [CMD_W-1:0] CMD_LOAD_FULL = 4'h2;
  localparam logic [CMD_W-1:0] CMD_LOAD_STD  = 4'h3;
  localparam logic [CMD_W-1:0] CMD_READ_ARR  = 4'h4;
  localparam logic [CMD_W-1:0] CMD_READ_SIG  = 4'h5;
  localparam logic [CMD_W-1:0] CMD_SECURE    = 4'h6;

  // Power-up reset window, longest time so rounded down
  localparam int CLK_PERIOD_NS = 20;
  localparam int PUR_TIME_NS   = 1000;
  localparam int PUR_CYCLES    = PUR_TIME_NS / CLK_PERIOD_NS;
  localparam int PUR_W         = 6;

  // Synchroniser idle levels: pull-down on data in, pull-ups elsewhere
  localparam logic SDI_IDLE  = 1'b0;
  localparam logic PULL_IDLE = 1'b1;

  // APB map
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_PRELOAD = 8'h04;
  localparam logic [7:0] OFF_STATUS  = 8'h08;
  localparam logic [7:0] OFF_SIG_LO  = 8'h0c;
  localparam logic [7:0] OFF_SIG_HI  = 8'h10;
  localparam logic [7:0] OFF_OUTQ    = 8'h14;

  // Field positions
  localparam int CTRL_PRELOAD_BIT = 0;
  localparam int ST_SESSION_BIT   = 0;
  localparam int ST_SECURE_BIT    = 1;
  localparam int ST_REFUSED_BIT   = 2;
  localparam int ST_PORDONE_BIT   = 3;
  localparam logic [OUT_NUM-1:0] PRELOAD_RST = 10'h000;

  typedef enum logic [2:0] {
    SP_IDLE, SP_CMD, SP_LOAD, SP_READ, SP_DONE
  } serial_state_t;

endpackage

// >>> design/serial_pin_sync.sv
// Two-stage synchronisers with edge detection for the serial port pins.
// Assumes pins are asynchronous to clk_sys; idle levels set per bit.
`timescale 1ns/10ps
`default_nettype none
module serial_pin_sync #(
  parameter int                 WIDTH = 3,
  parameter logic [WIDTH-1:0]   IDLE  = '0
) (
  input  wire logic             clk_sys,
  input  wire logic             rstSync_b,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;

  // One synchroniser per pin; stage1 feeds stage2 only
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : gSync
      always_ff @(posedge clk_sys or negedge rstSync_b) begin
        if (!rstSync_b) begin
          stage1_r[g] <= IDLE[g];
          stage2_r[g] <= IDLE[g];
          stage3_r[g] <= IDLE[g];
        end else begin
          stage1_r[g] <= pinIn[g];
          stage2_r[g] <= stage1_r[g];
          stage3_r[g] <= stage2_r[g];
        end
      end
    end
  endgenerate

  // Edges from settled stages only
  assign level = stage2_r;
  assign rise  = stage2_r & ~stage3_r;
  assign fall  = ~stage2_r & stage3_r;

endmodule // serial_pin_sync
`default_nettype wire

// >>> design/pld_config_loader.sv
// Configuration loader: serial programming port, configuration cells,
// user signature, security cell, output register preload and power-up reset.
// Assumes an APB master on clk_sys and serial pins from an outside programmer.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module pld_config_loader (
  input  wire logic                            clk_sys,
  input  wire logic                            rst_b,
  // APB slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [7:0]                      paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // Serial programming port
  input  wire logic                            serialProgIn,
  input  wire logic                            serialClk,
  input  wire logic                            progMode,
  output logic                                 serialProgOut,
  output logic                                 serialProgOutEn_b,
  // Registered outputs and their next state from the logic array
  input  wire logic                            regClkEn,
  input  wire logic [cfg_loader_pkg::OUT_NUM-1:0] nextState,
  output logic      [cfg_loader_pkg::OUT_NUM-1:0] regOut,
  output logic      [cfg_loader_pkg::OUT_NUM-1:0] regOutEn_b
);
  import cfg_loader_pkg::*;

  // Reset release through two flops
  logic rstMeta_r;
  logic rstSync_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  // Pin synchronisers: {mode, sclk, sdi}
  logic [2:0] pinLevel;
  logic [2:0] pinRise;
  logic [2:0] pinFall;

  serial_pin_sync #(
    .WIDTH (3),
    .IDLE  ({PULL_IDLE, PULL_IDLE, SDI_IDLE})
  ) uPinSync (
    .clk_sys   (clk_sys),
    .rstSync_b (rstSync_r),
    .pinIn     ({progMode, serialClk, serialProgIn}),
    .level     (pinLevel),
    .rise      (pinRise),
    .fall      (pinFall)
  );

  wire sdiLevel  = pinLevel[0];
  wire sclkRise  = pinRise[1];
  wire sclkFall  = pinFall[1];
  wire modeLevel = pinLevel[2];
  wire modeRise  = pinRise[2];

  // Non-volatile cells: deliberately outside the reset
  logic            cfgMem_r [0:ARRAY_CELLS-1];
  logic [63:0]     userSignature_r;
  logic            secure_r;

  // Serial sequencer state
  serial_state_t     spState_r;
  serial_state_t     spState_nxt;
  logic [CMD_W-1:0]  cmd_r;
  logic [IDX_W-1:0]  idx_r;
  logic              sdo_r;
  logic              refused_r;

  // Session opens only on mode rise with data in high; pulled-down sdi
  // therefore never starts programming by accident
  wire sessionOpen = modeRise & sdiLevel;
  wire sessionEnd  = ~modeLevel;

  wire [CMD_W-1:0] cmdShift = {sdiLevel, cmd_r[CMD_W-1:1]};
  wire cmdLastBit  = (idx_r == IDX_W'(CMD_W - 1));
  wire isLoadFull  = (cmd_r == CMD_LOAD_FULL);
  wire isReadArr   = (cmd_r == CMD_READ_ARR);
  wire isReadSig   = (cmd_r == CMD_READ_SIG);
  wire [IDX_W-1:0] loadLast = isLoadFull ? FULL_LAST : STD_LAST;
  wire [IDX_W-1:0] readLast = isReadSig ? SIG_LAST : STD_LAST;
  wire loadInArray = (idx_r < SIG_BASE);
  wire [IDX_W-1:0] sigIdxFull = idx_r - SIG_BASE;
  wire [5:0]       sigIdx     = sigIdxFull[5:0];

  // Decoded command at the last command bit
  wire cmdDone     = (spState_r == SP_CMD) & sclkRise & cmdLastBit;
  wire doErase     = cmdDone & (cmdShift == CMD_ERASE);
  wire doSecure    = cmdDone & (cmdShift == CMD_SECURE);
  wire refuseRead  = cmdDone & (cmdShift == CMD_READ_ARR) & secure_r;
  wire loadStrobe  = (spState_r == SP_LOAD) & sclkRise;
  wire readActive  = (spState_r == SP_READ);

  // Next bit offered on the data out pin
  wire arrBit  = secure_r ? 1'b0 : cfgMem_r[idx_r];
  wire sigBit  = userSignature_r[idx_r[5:0]];
  wire readBit = isReadSig ? sigBit : (isReadArr ? arrBit : 1'b0);

  // Sequencer transitions; command selects the data phase
  always_comb begin
    spState_nxt = spState_r;
    unique case (spState_r)
      SP_IDLE: begin
        if (sessionOpen) begin
          spState_nxt = SP_CMD;
        end
      end
      SP_CMD: begin
        if (sessionEnd) begin
          spState_nxt = SP_IDLE;
        end else if (cmdDone) begin
          if (cmdShift == CMD_LOAD_FULL || cmdShift == CMD_LOAD_STD) begin
            spState_nxt = SP_LOAD;
          end else if (cmdShift == CMD_READ_SIG ||
                       cmdShift == CMD_READ_ARR) begin
            spState_nxt = SP_READ;
          end else begin
            spState_nxt = SP_DONE;
          end
        end
      end
      SP_LOAD: begin
        if (sessionEnd) begin
          spState_nxt = SP_IDLE;
        end else if (sclkRise && idx_r == loadLast) begin
          spState_nxt = SP_DONE;
        end
      end
      SP_READ: begin
        if (sessionEnd) begin
          spState_nxt = SP_IDLE;
        end else if (sclkRise && idx_r == readLast) begin
          spState_nxt = SP_DONE;
        end
      end
      SP_DONE: begin
        if (sessionEnd) begin
          spState_nxt = SP_IDLE;
        end
      end
    endcase
  end

  // State, command shifter and cell index
  always_ff @(posedge clk_sys or negedge rstSync_r) begin
    if (!rstSync_r) begin
      spState_r <= SP_IDLE;
      cmd_r     <= '0;
      idx_r     <= '0;
    end else begin
      spState_r <= spState_nxt;
      if (spState_r == SP_IDLE) begin
        cmd_r <= '0;
        idx_r <= '0;
      end else if (spState_r == SP_CMD && sclkRise) begin
        cmd_r <= cmdShift;
        idx_r <= cmdLastBit ? '0 : idx_r + IDX_W'(1);
      end else if ((loadStrobe || readActive) && sclkRise) begin
        idx_r <= idx_r + IDX_W'(1);
      end
    end
  end

  // Data out changes on the falling serial clock so it is stable at rise
  always_ff @(posedge clk_sys or negedge rstSync_r) begin
    if (!rstSync_r) begin
      sdo_r <= 1'b0;
    end else if (!readActive) begin
      sdo_r <= 1'b0;
    end else if (sclkFall) begin
      sdo_r <= readBit;
    end
  end

  assign serialProgOut     = sdo_r;
  assign serialProgOutEn_b = ~readActive;

  // Array cells: erase clears them all, loads write one cell per serial clock rise
  always_ff @(posedge clk_sys) begin
    if (doErase) begin
      for (int i = 0; i < ARRAY_CELLS; i++) begin
        cfgMem_r[i] <= 1'b0;
      end
    end else if (loadStrobe && loadInArray) begin
      cfgMem_r[idx_r] <= sdiLevel;
    end
  end

  // Signature cells follow the array only in a full image
  always_ff @(posedge clk_sys) begin
    if (loadStrobe && !loadInArray && isLoadFull) begin
      userSignature_r[sigIdx] <= sdiLevel;
    end
  end

  // Security cell: set by command, cleared only together with the array
  always_ff @(posedge clk_sys) begin
    if (doErase) begin
      secure_r <= 1'b0;
    end else if (doSecure) begin
      secure_r <= 1'b1;
    end
  end

  // Power-up window: output registers held at zero unless preloaded, device clock ignored
  logic [PUR_W-1:0] purCount_r;
  logic             porDone_r;

  always_ff @(posedge clk_sys or negedge rstSync_r) begin
    if (!rstSync_r) begin
      purCount_r <= '0;
      porDone_r  <= 1'b0;
    end else if (!porDone_r) begin
      purCount_r <= purCount_r + PUR_W'(1);
      porDone_r  <= (purCount_r == PUR_W'(PUR_CYCLES - 1));
    end
  end

  // APB decode; zero wait states
  wire apbAccess = psel & penable;
  wire apbWr     = apbAccess & pwrite;
  wire hitCtrl   = (paddr == OFF_CTRL);
  wire hitPre    = (paddr == OFF_PRELOAD);
  wire hitStat   = (paddr == OFF_STATUS);
  wire hitSigLo  = (paddr == OFF_SIG_LO);
  wire hitSigHi  = (paddr == OFF_SIG_HI);
  wire hitOutQ   = (paddr == OFF_OUTQ);
  wire hitAny    = hitCtrl | hitPre | hitStat | hitSigLo | hitSigHi | hitOutQ;
  wire wrPreGo   = apbWr & hitCtrl & pwdata[CTRL_PRELOAD_BIT];
  wire wrRefClr  = apbWr & hitStat & pwdata[ST_REFUSED_BIT];

  // Preload value and a one-cycle apply request
  logic [OUT_NUM-1:0] preloadData_r;
  logic               preloadPend_r;

  always_ff @(posedge clk_sys or negedge rstSync_r) begin
    if (!rstSync_r) begin
      preloadData_r <= PRELOAD_RST;
      preloadPend_r <= 1'b0;
    end else begin
      if (apbWr && hitPre) begin
        preloadData_r <= pwdata[OUT_NUM-1:0];
      end
      preloadPend_r <= wrPreGo;
    end
  end

  // Sticky refusal flag; a new refusal beats a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rstSync_r) begin
    if (!rstSync_r) begin
      refused_r <= 1'b0;
    end else if (refuseRead) begin
      refused_r <= 1'b1;
    end else if (wrRefClr) begin
      refused_r <= 1'b0;
    end
  end

  // Output registers: preload bypasses the feedback from the array
  logic [OUT_NUM-1:0] outQ_r;

  always_ff @(posedge clk_sys or negedge rstSync_r) begin
    if (!rstSync_r) begin
      outQ_r <= '0;
    end else if (preloadPend_r) begin
      outQ_r <= preloadData_r;
    end else if (regClkEn && porDone_r) begin
      outQ_r <= nextState;
    end
  end

  // Pin levels from polarity and enable cells
  genvar g;
  generate
    for (g = 0; g < OUT_NUM; g++) begin : gOut
      assign regOut[g]     = outQ_r[g] ^ cfgMem_r[POL_CELL0 + g];
      assign regOutEn_b[g] = ~cfgMem_r[OE_CELL0 + g];
    end
  endgenerate

  // Status word
  wire [31:0] statusWord = {28'h0000000, porDone_r, refused_r, secure_r,
                            (spState_r != SP_IDLE)};

  // Read mux; unmapped reads return zero with an error
  assign prdata = hitStat  ? statusWord :
                  hitSigLo ? userSignature_r[31:0] :
                  hitSigHi ? userSignature_r[63:32] :
                  hitPre   ? {22'h000000, preloadData_r} :
                  hitOutQ  ? {22'h000000, outQ_r} :
                  32'h00000000;
  assign pready  = 1'b1;
  assign pslverr = apbAccess & ~hitAny;

endmodule // pld_config_loader
`default_nettype wire

// >>> sim/prog_driver.sv
// Programmer model: drives the serial pins of the loader at 160 ns a bit.
// Assumes its tasks are called one at a time by the bench.
`timescale 1ns/10ps
`default_nettype none
module prog_driver (
  output logic     serialProgIn,
  output logic     serialClk,
  output logic     progMode,
  input wire logic serialProgOut,
  input wire logic serialProgOutEn_b
);
  logic lastOut = 1'b0;

  // Idle pins: data in released to its pull-down, clock still
  initial begin
    serialProgIn = 1'b0;
    serialClk = 1'b0;
    progMode = 1'b0;
  end

  // One bit: low half, sample, rising edge, high half
  task automatic bit_cycle(input logic din, output logic dout);
    serialProgIn = din;
    #80;
    // Undriven line shows no stale value
    dout = serialProgOutEn_b ? ~lastOut : serialProgOut;
    lastOut = dout;
    serialClk = 1'b1;
    #80;
    serialClk = 1'b0;
  endtask

  // Key held across mode rise, then command LSB first
  task automatic open_cmd(input logic [3:0] cmd, input logic key);
    logic d;
    #7;  // Off the system clock phase
    serialProgIn = key;
    #80;
    progMode = 1'b1;
    #160;
    for (int i = 0; i < 4; i++) bit_cycle(cmd[i], d);
  endtask

  // Mode low ends any session; data in released
  task automatic close_session();
    #80;
    progMode = 1'b0;
    serialProgIn = 1'b0;
    #160;
  endtask
endmodule  // prog_driver
`default_nettype wire

// >>> sim/pld_loader_assertions.sv
// Checker for the configuration loader, bound to its top module.
// Assumes clk_sys is the only clock and rst_b the async reset.
`timescale 1ns/10ps
`default_nettype none
module pld_loader_checker (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        serialProgIn,
  input wire logic        serialClk,
  input wire logic        progMode,
  input wire logic        serialProgOut,
  input wire logic        serialProgOutEn_b,
  input wire logic        regClkEn,
  input wire logic [cfg_loader_pkg::OUT_NUM-1:0] nextState,
  input wire logic [cfg_loader_pkg::OUT_NUM-1:0] regOut,
  input wire logic [cfg_loader_pkg::OUT_NUM-1:0] regOutEn_b
);
  import cfg_loader_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire logic apbWr = psel && penable && pwrite;
  logic [5:0] relCnt_r;
  logic       rstSeen_r;

  // Cycles since reset release, saturating
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) relCnt_r <= 6'h00;
    else if (relCnt_r != 6'h3f) relCnt_r <= relCnt_r + 6'h01;
  end

  // Reset already seen at an earlier edge, so the async reset has settled
  always_ff @(posedge clk_sys) rstSeen_r <= !rst_b;

  a_sdo_idle_low: assert property (serialProgOutEn_b &&
    $past(serialProgOutEn_b) |-> !serialProgOut)
    else $error("data out not low while disabled");
  a_mode_low_release: assert property ((!progMode)[*5]
    |-> serialProgOutEn_b) else $error("data out driven outside session");
  a_sdo_holds_high: assert property ((serialClk[*3] ##0
    !serialProgOutEn_b) |-> serialProgOut === $past(serialProgOut))
    else $error("data out moved while serial clock high");
  a_regs_keep_state: assert property ((!progMode && !regClkEn
    && !apbWr)[*4] |=> regOut === $past(regOut))
    else $error("outputs moved without cause");
  a_por_clk_ignored: assert property ((relCnt_r < 6'h28 &&
    regClkEn && !progMode && !$past(apbWr)) |=> regOut === $past(regOut))
    else $error("register clocked inside power-up window");
  a_sig_read_ok: assert property (psel && penable &&
    (paddr == OFF_SIG_LO || paddr == OFF_SIG_HI) |-> pready && !pslverr)
    else $error("signature read not answered");
  a_low_key_closed: assert property (($rose(progMode) &&
    !serialProgIn && !$past(serialProgIn)) |=> serialProgOutEn_b[*8])
    else $error("session opened with data in low");
  a_reset_quiet: assert property (disable iff (1'b0)
    !rst_b && rstSeen_r |-> serialProgOutEn_b && !serialProgOut)
    else $error("data out active in reset");
endmodule  // pld_loader_checker

bind pld_config_loader pld_loader_checker i_chk (.clk_sys, .rst_b, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .serialProgIn, .serialClk, .progMode, .serialProgOut, .serialProgOutEn_b,
  .regClkEn, .nextState, .regOut, .regOutEn_b);
`default_nettype wire

// >>> sim/pld_config_loader_bench.sv
// Self-checking bench: APB register accesses and serial sessions.
// Assumes the loader top module, its package and the programmer model.
`timescale 1ns/10ps
`default_nettype none
module pld_config_loader_bench;
  import cfg_loader_pkg::*;
  localparam logic [63:0] SIG_VAL = 64'h5a3c_9e01_2f7b_c468;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        regClkEn = 1'b0;
  logic [9:0]  nextState = 10'h000;
  logic [9:0]  pol;
  logic [9:0]  oe;
  wire logic [31:0] prdata;
  wire logic        pready, pslverr, serialProgIn, serialClk, progMode;
  wire logic        serialProgOut, serialProgOutEn_b;
  wire logic [9:0]  regOut, regOutEn_b;
  int mismatches = 0;
  int check_count = 0;

  pld_config_loader i_dut (.clk_sys, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .serialProgIn, .serialClk,
    .progMode, .serialProgOut, .serialProgOutEn_b, .regClkEn, .nextState,
    .regOut, .regOutEn_b);
  prog_driver i_prog (.serialProgIn, .serialClk, .progMode, .serialProgOut,
    .serialProgOutEn_b);

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  function automatic logic cellBit(input int i);
    return (i % 3) == 0;
  endfunction

  task automatic print_verdict();
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; pready ends the wait, capped at 20 cycles
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t bus wait ran out", $time);
      print_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    check(rd & m, exp);
  endtask

  // Whole session: command, then n image cells
  task automatic sess(input logic [3:0] cmd, input int n);
    logic d;
    i_prog.open_cmd(cmd, 1'b1);
    for (int i = 0; i < n; i++)
      i_prog.bit_cycle(i < ARRAY_CELLS ? cellBit(i)
                       : SIG_VAL[i - ARRAY_CELLS], d);
    i_prog.close_session();
  endtask

  // Read n bits back; a refused array read gives zeros
  task automatic readBits(input logic [3:0] cmd, input int n,
                          input logic sec);
    logic d;
    i_prog.open_cmd(cmd, 1'b1);
    for (int i = 0; i < n; i++) begin
      i_prog.bit_cycle(1'b0, d);
      if (i == 0) check(serialProgOutEn_b, 1'b0);
      check(d, cmd == CMD_READ_SIG ? SIG_VAL[i]
            : (sec ? 1'b0 : cellBit(i)));
    end
    i_prog.close_session();
  endtask

  task automatic pulse(input logic [9:0] ns);
    @(posedge clk_sys);
    regClkEn <= 1'b1;
    nextState <= ns;
    @(posedge clk_sys);
    regClkEn <= 1'b0;
  endtask

  // Main sequence
  initial begin
    logic [31:0] rd;
    logic        err;
    for (int k = 0; k < OUT_NUM; k++) begin
      pol[k] = cellBit(POL_CELL0 + k);
      oe[k] = cellBit(OE_CELL0 + k);
    end
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    i_prog.open_cmd(CMD_READ_SIG, 1'b0);
    rdChk(OFF_STATUS, 32'h1, 32'h0);
    i_prog.close_session();
    apb(1'b0, 8'h40, 32'h0, rd, err);
    check(err, 1'b1);
    check(rd, 32'h0);
    sess(CMD_ERASE, 0);
    sess(CMD_LOAD_FULL, FULL_CELLS);
    readBits(CMD_READ_SIG, SIG_CELLS, 1'b0);
    rdChk(OFF_SIG_LO, 32'hffffffff, SIG_VAL[31:0]);
    rdChk(OFF_SIG_HI, 32'hffffffff, SIG_VAL[63:32]);
    readBits(CMD_READ_ARR, 16, 1'b0);
    sess(CMD_LOAD_STD, ARRAY_CELLS);
    readBits(CMD_READ_SIG, SIG_CELLS, 1'b0);
    check(regOut, pol);
    check(regOutEn_b, {22'h0, ~oe});
    sess(CMD_SECURE, 0);
    rdChk(OFF_STATUS, 32'h2, 32'h2);
    readBits(CMD_READ_SIG, SIG_CELLS, 1'b1);
    readBits(CMD_READ_ARR, 16, 1'b1);
    rdChk(OFF_STATUS, 32'h4, 32'h4);
    wr(OFF_STATUS, 32'h4);
    rdChk(OFF_STATUS, 32'h4, 32'h0);
    // Second reset: cells kept, power-up window again
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rdChk(OFF_STATUS, 32'h8, 32'h0);
    pulse(10'h3ff);
    rdChk(OFF_OUTQ, 32'h3ff, 32'h0);
    check(regOut, pol);
    repeat (60) @(posedge clk_sys);
    rdChk(OFF_STATUS, 32'h8, 32'h8);
    pulse(10'h155);
    rdChk(OFF_OUTQ, 32'h3ff, 32'h155);
    check(regOut, 10'h155 ^ pol);
    readBits(CMD_READ_SIG, SIG_CELLS, 1'b1);
    wr(OFF_PRELOAD, 32'h2a5);
    rdChk(OFF_PRELOAD, 32'h3ff, 32'h2a5);
    wr(OFF_CTRL, 32'h1);
    rdChk(OFF_OUTQ, 32'h3ff, 32'h2a5);
    check(regOut, 10'h2a5 ^ pol);
    sess(CMD_ERASE, 0);
    rdChk(OFF_STATUS, 32'h2, 32'h0);
    print_verdict();
  end
endmodule  // pld_config_loader_bench
`default_nettype wire
